// file: verif/spc_host_model.sv
// spi host master model: mode 0 frames, clock still outside frames
`timescale 1ns/1ps
module spc_host_model (
  input wire logic mclk,
  output logic sclk, cs_n, mosi,
  input wire logic miso
);
  initial {sclk, cs_n, mosi} = 3'h2;
  task automatic tick(input int n); repeat (n) @(posedge mclk); #1; endtask
  task automatic sel(); cs_n = 0; tick(4); endtask
  task automatic desel(); tick(2); cs_n = 1; tick(10); endtask
  // one byte msb first: drive while low, sample at rise, 80 ns period
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      mosi = b[i]; tick(4); sclk = 1; r[i] = miso; tick(4); sclk = 0;
    end
  endtask
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
    c ^= b;
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    return c;
  endfunction
  // header, payload low byte first, crc msb first; bad flips the crc lsb
  task automatic pkt(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d[$], input logic bad);
    logic [7:0] q[$];
    logic [7:0] r;
    logic [15:0] c;
    q = {op, a[23:16], a[15:8], a[7:0], 8'h00, 8'(d.size())};
    q = {q, d};
    c = 16'h0000;
    foreach (q[i]) c = crc(c, q[i]);
    c ^= {15'h0, bad};
    q = {q, c[15:8], c[7:0]};
    sel(); foreach (q[i]) xfer(q[i], r); desel();
  endtask
  task automatic cmd(input logic [7:0] op, input int n, output logic [7:0] r);
    sel(); xfer(op, r); repeat (n) xfer(8'h00, r); desel();
  endtask
  // read of two bytes, waiting 1.5 us after the header
  task automatic rd(input logic [23:0] a, output logic [7:0] r0, r1);
    logic [7:0] h[$];
    h = {8'h0B, a[23:16], a[15:8], a[7:0], 8'h00, 8'h02};
    sel(); foreach (h[i]) xfer(h[i], r0); tick(150); xfer(8'h00, r0); xfer(8'h00, r1); desel();
  endtask
endmodule

// file: verif/spc_slave_sva.sv
// port assertions of the packet slave
`timescale 1ns/1ps
module spc_slave_sva import spc_pkg::*; (
  input wire logic mclk, nrst, spi_cs_n, spi_miso_oe_n, rd_req, wr_valid, wr_ready,
  input wire logic cfg_restore, soft_restart, write_enabled, busy,
  input wire spc_wr_word_t wr_word
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // chip select held off, and held on, long enough to pass the synchroniser
  sequence s_desel; spi_cs_n [*6]; endsequence
  sequence s_sel; (!spi_cs_n) [*5]; endsequence
  property p_oe; s_desel |-> spi_miso_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("miso driven while deselected");
  property p_cr; cfg_restore |-> write_enabled ##1 !cfg_restore; endproperty
  a_cr: assert property (p_cr) else $error("bad restore pulse");
  property p_sr; soft_restart |=> !soft_restart; endproperty
  a_sr: assert property (p_sr) else $error("long restart pulse");
  property p_rd; rd_req |=> !rd_req; endproperty
  a_rd: assert property (p_rd) else $error("long read request");
  property p_hold; wr_valid && !wr_ready |=> wr_valid && $stable(wr_word); endproperty
  a_hold: assert property (p_hold) else $error("word lost in stall");
  property p_wen; wr_valid |-> write_enabled && busy; endproperty
  a_wen: assert property (p_wen) else $error("word while locked or idle");
  property p_ro; wr_valid |-> !(wr_word.addr inside {[INFO_BASE:INFO_END - 1], [DLIST_BASE:DLIST_END - 1]}); endproperty
  a_ro: assert property (p_ro) else $error("word into read-only bank");
  property p_lock; s_sel |-> $stable(write_enabled); endproperty
  a_lock: assert property (p_lock) else $error("flag moved inside frame");
endmodule
bind spc_slave_top spc_slave_sva u_sva (.mclk, .nrst, .spi_cs_n, .spi_miso_oe_n, .rd_req, .wr_valid, .wr_ready,
  .cfg_restore, .soft_restart, .write_enabled, .busy, .wr_word);

// file: verif/spc_slave_top_tb.sv
// self-checking bench of the packet slave
`timescale 1ns/1ps
module spc_slave_top_tb;
  import spc_pkg::*;
  logic mclk = 0, nrst = 0, ce = 1, rd_valid = 0, wr_ready = 0, stall = 0;
  logic [7:0] rd_data = 8'h00, r, r1;
  logic sclk, cs_n, mosi, miso, oe_n, rd_req, wr_valid, cfgr, srst, wen, busy;
  logic [2:0] rq = 3'h0;
  logic [23:0] rd_addr;
  logic [23:0] bases[5] = '{CFG0_BASE, CFG1_BASE, GSTAT_BASE, DSTAT_BASE, TXN_BASE};
  logic [7:0] d[$];
  spc_wr_word_t wr_word, exp_q[$];
  int n_errors = 0, samples_checked = 0, n_cr = 0, n_sr = 0;
  // released miso shows the inverse of its last level
  wire miso_w = oe_n ? ~miso : miso;
  always #5 mclk = ~mclk;
  spc_slave_top dut (.mclk, .nrst, .ce, .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
    .spi_miso_oe_n(oe_n), .rd_req, .rd_addr, .rd_valid, .rd_data, .wr_valid, .wr_ready, .wr_word,
    .cfg_restore(cfgr), .soft_restart(srst), .write_enabled(wen), .busy);
  spc_host_model host (.mclk, .sclk, .cs_n, .mosi, .miso(miso_w));
  // memory answers three cycles after each request; sink stalls at random
  always @(posedge mclk)
  begin
    rq <= {rq[1:0], rd_req};
    rd_valid <= #1 rq[1];
    rd_data <= #1 rd_addr[7:0] ^ 8'hA5;
    wr_ready <= #1 !stall && ($urandom % 3 != 0);
    n_cr += (cfgr === 1'b1);
    n_sr += (srst === 1'b1);
  end
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  // each accepted word is taken against the oldest note
  always @(posedge mclk)
    if (nrst && wr_valid === 1'b1 && wr_ready === 1'b1)
      chk("wr_word", exp_q.size() ? exp_q.pop_front() : 32'hFFFF_FFFF, wr_word);
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic drain();
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge mclk);
    #1 chk("pending", 0, exp_q.size());
    chk("busy", 0, busy);
  endtask
  initial
  begin
    #1000000 n_errors++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(32'h1c91_3593));
    repeat (4) @(posedge mclk);
    #1 nrst = 1;
    repeat (6) @(posedge mclk);
    #1 host.cmd(STATUS_READ_CMD, 1, r);
    chk("status", 8'h00, r);
    d = {8'h11, 8'h22};
    host.pkt(WRITE_CMD, 24'h00_0100, d, 0);
    drain();
    host.cmd(WRITE_UNLOCK_CMD, 0, r);
    host.cmd(STATUS_READ_CMD, 1, r);
    chk("status", 8'h02, r);
    // six words against a stalled sink fill the fifo
    d = {};
    for (int i = 0; i < 6; i++)
    begin
      d.push_back(8'($urandom));
      exp_q.push_back({24'h20_0010 + 24'(i), d[i]});
    end
    stall = 1;
    host.pkt(WRITE_CMD, 24'h20_0010, d, 0);
    host.cmd(STATUS_READ_CMD, 1, r);
    chk("status", 8'h03, r);
    // a write arriving while busy is dropped whole
    host.pkt(WRITE_CMD, 24'h20_0040, d, 0);
    stall = 0;
    drain();
    host.pkt(WRITE_CMD, 24'h20_0010, d, 1);
    host.pkt(WRITE_CMD, INFO_BASE, d, 0);
    host.pkt(WRITE_CMD, DLIST_BASE, d, 0);
    d = {};
    host.pkt(WRITE_CMD, TXN_BASE, d, 0);
    drain();
    foreach (bases[i])
    begin
      d = {8'(i)};
      exp_q.push_back({bases[i], 8'(i)});
      host.pkt(WRITE_CMD, bases[i], d, 0);
      drain();
    end
    host.rd(DSTAT_BASE + 24'h00_00FE, r, r1);
    chk("rd0", 8'hFE ^ 8'hA5, r);
    chk("rd1", 8'hFF ^ 8'hA5, r1);
    host.cmd(CFG_RESTORE_CMD, 0, r);
    host.cmd(SOFT_RESTART_CMD, 0, r);
    chk("restore", 1, n_cr);
    chk("restart", 1, n_sr);
    host.cmd(WRITE_LOCK_CMD, 0, r);
    host.cmd(STATUS_READ_CMD, 1, r);
    chk("status", 8'h00, r);
    host.cmd(CFG_RESTORE_CMD, 0, r);
    chk("restore", 1, n_cr);
    print_verdict();
  end
endmodule

// file: verilog/spc_buf.sv
// payload buffer memory with registered read data
`timescale 1ns/1ps
module spc_buf (
  // clock and enable
  input wire logic mclk,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [spc_pkg::BUF_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // read port
  input wire logic [spc_pkg::BUF_AW-1:0] raddr,
  output logic [7:0] rdata
);
  import spc_pkg::*;

  // storage array, no reset needed
  logic [7:0] mem [BUF_DEPTH];

  // ==========================================================================
  // write and registered read
  // ==========================================================================
  always_ff @(posedge mclk)
  begin
    if (ce)
    begin
      if (we)
      begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule

// file: verilog/spc_fifo.sv
// small word fifo with valid and ready on both sides
`timescale 1ns/1ps
module spc_fifo #(
  parameter int W = 32,
  parameter int DEPTH = spc_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  import spc_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // whole fifo state
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } spc_fifo_st_t;

  spc_fifo_st_t q;
  spc_fifo_st_t d;
  logic push;
  logic pop;

  // pointer step with wrap at the depth
  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // honest full and empty
  assign in_ready = (q.cnt != CW'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wp] = in_data;
      d.wp = next_ptr(q.wp);
    end
    if (pop)
    begin
      d.rp = next_ptr(q.rp);
    end
    // count moves only when one side acts alone
    if (push && !pop)
    begin
      d.cnt = CW'(q.cnt + 1'b1);
    end
    else if (pop && !push)
    begin
      d.cnt = CW'(q.cnt - 1'b1);
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else if (ce)
    begin
      q <= d;
    end
  end
endmodule

// file: verilog/spc_pkg.sv
// shared constants, carrier types and helper functions of the spi packet command slave
package spc_pkg;

  // ==========================================================================
  // opcodes
  // ==========================================================================
  localparam logic [7:0] READ_CMD = 8'h0B;          // memory read
  localparam logic [7:0] WRITE_CMD = 8'h02;         // memory write
  localparam logic [7:0] CFG_RESTORE_CMD = 8'hC7;   // restore default configuration
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;   // return status byte
  localparam logic [7:0] WRITE_UNLOCK_CMD = 8'h06;  // set write-enable flag
  localparam logic [7:0] WRITE_LOCK_CMD = 8'h04;    // clear write-enable flag
  localparam logic [7:0] SOFT_RESTART_CMD = 8'h99;  // restart the receiver

  // ==========================================================================
  // packet layout (byte index from opcode = 0)
  // ==========================================================================
  localparam logic [15:0] ADDR_LAST_IDX = 16'h0003;  // last address byte
  localparam logic [15:0] HDR_LAST_IDX = 16'h0005;   // last size byte
  localparam logic [15:0] PAY_FIRST_IDX = 16'h0006;  // first payload byte
  localparam logic [15:0] CRC_LAST_OFS = 16'h0007;   // crc low byte at size + this
  localparam logic [15:0] MIN_PAYLOAD = 16'h0001;    // shortest write
  localparam logic [15:0] MAX_PAYLOAD = 16'h0200;    // longest write, also buffer depth
  localparam int BUF_AW = 9;                         // payload buffer address width
  localparam int BUF_DEPTH = 512;                    // payload buffer bytes
  localparam int FIFO_DEPTH = 4;                     // write stream fifo words

  // ==========================================================================
  // status byte and crc
  // ==========================================================================
  localparam int STAT_BUSY_BIT = 0;                  // 1 while busy
  localparam int STAT_WEN_BIT = 1;                   // 1 while writes enabled
  localparam logic [15:0] CRC_INIT = 16'h0000;       // crc start value
  localparam logic [15:0] CRC_POLY_REFL = 16'hA001;  // reflected 0x8005 polynomial

  // ==========================================================================
  // memory banks (end addresses exclusive)
  // ==========================================================================
  localparam logic [23:0] CFG0_BASE = 24'h00_0000;
  localparam logic [23:0] CFG0_END = 24'h10_0000;
  localparam logic [23:0] CFG1_BASE = 24'h20_0000;
  localparam logic [23:0] CFG1_END = 24'h28_0000;
  localparam logic [23:0] INFO_BASE = 24'h40_0000;
  localparam logic [23:0] INFO_END = 24'h42_0000;
  localparam logic [23:0] GSTAT_BASE = 24'h48_0000;
  localparam logic [23:0] GSTAT_END = 24'h4A_0000;
  localparam logic [23:0] DSTAT_BASE = 24'h4C_0000;
  localparam logic [23:0] DSTAT_END = 24'h4E_0000;
  localparam logic [23:0] DLIST_BASE = 24'h50_0000;
  localparam logic [23:0] DLIST_END = 24'h60_0000;
  localparam logic [23:0] TXN_BASE = 24'hFF_FB00;
  localparam logic [23:0] TXN_END = 24'hFF_FF00;

  // bank codes
  typedef enum logic [2:0] {
    BANK_NONE = 3'h0,
    BANK_CFG0 = 3'h1,
    BANK_CFG1 = 3'h2,
    BANK_GSTAT = 3'h3,
    BANK_DSTAT = 3'h4,
    BANK_TXN = 3'h5,
    BANK_INFO = 3'h6,
    BANK_DLIST = 3'h7
  } spc_bank_t;

  // ==========================================================================
  // types
  // ==========================================================================
  // one word of the write stream
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] data;
  } spc_wr_word_t;

  // two-flop synchroniser plus edge history
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } spc_sync_t;

  // packet engine states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_HDR = 8'h02,
    ST_PAY = 8'h04,
    ST_CRC = 8'h08,
    ST_READ = 8'h10,
    ST_STAT = 8'h20,
    ST_CMD = 8'h40,
    ST_SKIP = 8'h80
  } spc_state_t;

  // whole state of the packet engine
  typedef struct packed {
    spc_sync_t sclk;
    spc_sync_t cs;
    spc_sync_t mosi;
    spc_state_t st;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [15:0] byte_idx;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [15:0] size;
    logic [15:0] crc_calc;
    logic [15:0] crc_rx;
    logic [7:0] tx_sh;
    logic miso;
    logic oe_n;
    logic wen;
    logic rd_first;
    logic rd_have;
    logic [7:0] rd_buf;
    logic [23:0] rd_addr;
    logic rd_req;
    logic dr_act;
    logic dr_ph;
    logic [9:0] dr_ptr;
    logic [9:0] dr_len;
    logic [23:0] dr_addr;
    logic cfg_restore;
    logic soft_restart;
  } spc_core_t;

  // ==========================================================================
  // functions
  // ==========================================================================
  // reset value of the engine: idle, pins released, chip select seen high
  function automatic spc_core_t spc_core_rst();
    spc_core_t r;
    r = '0;
    r.st = ST_IDLE;
    r.oe_n = 1'b1;
    r.cs = '1;
    r.crc_calc = CRC_INIT;
    return r;
  endfunction

  // crc16 update by one byte, bits taken lsb first
  function automatic logic [15:0] spc_crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction

  // which bank an address falls in
  function automatic spc_bank_t spc_bank_of(input logic [23:0] a);
    spc_bank_t b;
    b = BANK_NONE;
    if (a >= CFG0_BASE && a < CFG0_END) b = BANK_CFG0;
    else if (a >= CFG1_BASE && a < CFG1_END) b = BANK_CFG1;
    else if (a >= INFO_BASE && a < INFO_END) b = BANK_INFO;
    else if (a >= GSTAT_BASE && a < GSTAT_END) b = BANK_GSTAT;
    else if (a >= DSTAT_BASE && a < DSTAT_END) b = BANK_DSTAT;
    else if (a >= DLIST_BASE && a < DLIST_END) b = BANK_DLIST;
    else if (a >= TXN_BASE && a < TXN_END) b = BANK_TXN;
    return b;
  endfunction

  // banks that accept writes
  function automatic logic spc_bank_writable(input spc_bank_t b);
    return (b == BANK_CFG0) || (b == BANK_CFG1) || (b == BANK_GSTAT) || (b == BANK_DSTAT) || (b == BANK_TXN);
  endfunction

endpackage

// file: verilog/spc_slave_top.sv
// spi packet command slave: packet decode, status byte, banked write and read streams
// Notes on behaviour
// - mode 0: sample rising, drive falling edge
// - opcode, 24-bit address, 16-bit size, payload
// - trailing crc16 ibm over header and payload
// - address, crc msb first; payload lsb first
// - read returns memory data after host wait
// - write stores 1 to 512 payload bytes
// - config restore at deselect, only if unlocked
// - status command returns the status byte
// - unlock command sets write-enable flag
// - lock command clears write-enable flag
// - soft restart command pulses receiver restart
// - status bit1 write-enable, bit0 busy, rest zero
// - address decoded into configuration, status, transaction banks
// - information and detection banks never written
`timescale 1ns/1ps
module spc_slave_top (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // spi pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  // memory read port
  output logic rd_req,
  output logic [23:0] rd_addr,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  // memory write stream
  output logic wr_valid,
  input wire logic wr_ready,
  output spc_pkg::spc_wr_word_t wr_word,
  // control and status
  output logic cfg_restore,
  output logic soft_restart,
  output logic write_enabled,
  output logic busy
);
  import spc_pkg::*;

  // ==========================================================================
  // declarations
  // ==========================================================================
  logic [1:0] rst_sync;        // reset release chain
  logic rst_n;                 // released reset
  spc_core_t q;                // engine state
  spc_core_t d;                // engine next state
  logic sel;                   // chip select active
  logic sck_rise;              // spi clock rising edge
  logic sck_fall;              // spi clock falling edge
  logic cs_fall;               // start of frame
  logic cs_rise;               // end of frame
  logic [7:0] rx_byte;         // byte completed at this rising edge
  logic [7:0] status_byte;     // assembled status byte
  logic [15:0] pay_idx;        // payload byte number
  logic [23:0] wr_last;        // last address of a write
  logic wr_ok;                 // write packet passes opcode, size, lock and bank checks
  logic buf_we;                // payload buffer write
  logic [BUF_AW-1:0] buf_waddr;
  logic [7:0] buf_wdata;
  logic [7:0] buf_rdata;
  logic fifo_in_valid;         // drain offers a word
  logic fifo_in_ready;         // fifo has room
  spc_wr_word_t fifo_in;

  // ==========================================================================
  // reset release
  // ==========================================================================
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================================================
  // pin edges, read only from second and third flops
  // ==========================================================================
  assign sel = ~q.cs.s2;
  assign sck_rise = q.sclk.s2 & ~q.sclk.prev;
  assign sck_fall = ~q.sclk.s2 & q.sclk.prev;
  assign cs_fall = ~q.cs.s2 & q.cs.prev;
  assign cs_rise = q.cs.s2 & ~q.cs.prev;
  assign rx_byte = {q.rx_sh[6:0], q.mosi.s2};
  assign pay_idx = q.byte_idx - PAY_FIRST_IDX;
  assign busy = q.dr_act | wr_valid;

  // status byte, reserved bits read zero
  always_comb
  begin
    status_byte = '0;
    status_byte[STAT_WEN_BIT] = q.wen;
    status_byte[STAT_BUSY_BIT] = busy;
  end

  // write range must lie inside one writable bank
  assign wr_last = q.addr + 24'(q.size) - 24'h00_0001;
  assign wr_ok = (q.opcode == WRITE_CMD) && (q.size >= MIN_PAYLOAD) && (q.size <= MAX_PAYLOAD)
    && q.wen
    && (spc_bank_of(q.addr) == spc_bank_of(wr_last))
    && spc_bank_writable(spc_bank_of(q.addr));

  // ==========================================================================
  // engine next state
  // ==========================================================================
  always_comb
  begin
    d = q;
    buf_we = 1'b0;
    buf_waddr = pay_idx[BUF_AW-1:0];
    buf_wdata = rx_byte;
    fifo_in_valid = 1'b0;
    fifo_in.addr = q.dr_addr + 24'(q.dr_ptr);
    fifo_in.data = buf_rdata;
    // pins pass two flops before use
    d.sclk = '{s1: spi_sclk, s2: q.sclk.s1, prev: q.sclk.s2};
    d.cs = '{s1: spi_cs_n, s2: q.cs.s1, prev: q.cs.s2};
    d.mosi = '{s1: spi_mosi, s2: q.mosi.s1, prev: q.mosi.s2};
    // one-cycle pulses
    d.rd_req = 1'b0;
    d.cfg_restore = 1'b0;
    d.soft_restart = 1'b0;
    // read data from memory is held until shifted out
    if (rd_valid)
    begin
      d.rd_buf = rd_data;
      d.rd_have = 1'b1;
    end
    if (cs_fall)
    begin
      // new frame: clear framing and crc, take the miso pin
      d.st = ST_IDLE;
      d.bit_cnt = '0;
      d.byte_idx = '0;
      d.crc_calc = CRC_INIT;
      d.tx_sh = '0;
      d.miso = 1'b0;
      d.oe_n = 1'b0;
      d.rd_have = 1'b0;
      d.rd_first = 1'b0;
    end
    else if (cs_rise)
    begin
      // end of frame: single opcodes take effect here
      if (q.st == ST_CMD)
      begin
        case (q.opcode)
          WRITE_UNLOCK_CMD: d.wen = 1'b1;
          WRITE_LOCK_CMD: d.wen = 1'b0;
          CFG_RESTORE_CMD: d.cfg_restore = q.wen;
          SOFT_RESTART_CMD: d.soft_restart = 1'b1;
          default: d.cfg_restore = 1'b0;
        endcase
      end
      d.st = ST_IDLE;
      d.oe_n = 1'b1;
      d.bit_cnt = '0;
    end
    else if (sel && sck_fall)
    begin
      // drive next bit msb first
      d.miso = q.tx_sh[7];
      d.tx_sh = {q.tx_sh[6:0], 1'b0};
    end
    else if (sel && sck_rise)
    begin
      // sample one bit
      d.rx_sh = rx_byte;
      d.bit_cnt = q.bit_cnt + 3'h1;
      if (q.bit_cnt == 3'h7)
      begin
        d.byte_idx = q.byte_idx + 16'h0001;
        case (q.st)
          ST_IDLE:
          begin
            // opcode byte
            d.opcode = rx_byte;
            d.crc_calc = spc_crc_byte(CRC_INIT, rx_byte);
            case (rx_byte)
              READ_CMD: d.st = ST_HDR;
              WRITE_CMD: d.st = busy ? ST_SKIP : ST_HDR;
              STATUS_READ_CMD:
              begin
                d.st = ST_STAT;
                d.tx_sh = status_byte;
              end
              WRITE_UNLOCK_CMD, WRITE_LOCK_CMD, CFG_RESTORE_CMD, SOFT_RESTART_CMD: d.st = ST_CMD;
              default: d.st = ST_SKIP;
            endcase
          end
          ST_HDR:
          begin
            // address then size, both msb first
            d.crc_calc = spc_crc_byte(q.crc_calc, rx_byte);
            if (q.byte_idx <= ADDR_LAST_IDX)
            begin
              d.addr = {q.addr[15:0], rx_byte};
            end
            else
            begin
              d.size = {q.size[7:0], rx_byte};
            end
            if (q.byte_idx == HDR_LAST_IDX)
            begin
              if (q.opcode == READ_CMD)
              begin
                // fetch first byte during the host's wait
                d.st = ST_READ;
                d.rd_first = 1'b1;
                d.rd_have = 1'b0;
                d.rd_addr = q.addr;
                d.rd_req = 1'b1;
              end
              else if ({q.size[7:0], rx_byte} == '0)
              begin
                d.st = ST_CRC;
              end
              else
              begin
                d.st = ST_PAY;
              end
            end
          end
          ST_PAY:
          begin
            // payload lands in the buffer in arrival order
            d.crc_calc = spc_crc_byte(q.crc_calc, rx_byte);
            buf_we = (pay_idx < MAX_PAYLOAD);
            if (q.byte_idx == q.size + HDR_LAST_IDX)
            begin
              d.st = ST_CRC;
            end
          end
          ST_CRC:
          begin
            // received crc, msb first
            d.crc_rx = {q.crc_rx[7:0], rx_byte};
            if (q.byte_idx == q.size + CRC_LAST_OFS)
            begin
              d.st = ST_SKIP;
              if (({q.crc_rx[7:0], rx_byte} == q.crc_calc) && wr_ok)
              begin
                d.dr_act = 1'b1;
                d.dr_ph = 1'b0;
                d.dr_ptr = '0;
                d.dr_len = q.size[9:0];
                d.dr_addr = q.addr;
              end
            end
          end
          ST_READ:
          begin
            // next data byte, then prefetch the one after
            if (!q.rd_first)
            begin
              d.tx_sh = q.rd_buf;
              d.rd_have = 1'b0;
              d.rd_addr = q.rd_addr + 24'h00_0001;
              d.rd_req = 1'b1;
            end
          end
          ST_STAT: d.tx_sh = status_byte;
          default: d.st = q.st;
        endcase
      end
    end
    // first read byte arrives after the header: put its msb on the pin now
    if (q.st == ST_READ && q.rd_first && q.rd_have && sel && !cs_fall)
    begin
      d.miso = q.rd_buf[7];
      d.tx_sh = {q.rd_buf[6:0], 1'b0};
      d.rd_first = 1'b0;
      d.rd_have = 1'b0;
      d.rd_addr = q.rd_addr + 24'h00_0001;
      d.rd_req = 1'b1;
    end
    // drain checked payload into the write stream
    if (q.dr_act)
    begin
      if (!q.dr_ph)
      begin
        d.dr_ph = 1'b1;
      end
      else
      begin
        fifo_in_valid = 1'b1;
        if (fifo_in_ready)
        begin
          d.dr_ph = 1'b0;
          d.dr_ptr = q.dr_ptr + 10'h001;
          if (q.dr_ptr == q.dr_len - 10'h001)
          begin
            d.dr_act = 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================================
  // engine register
  // ==========================================================================
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= spc_core_rst();
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  // ==========================================================================
  // payload buffer and write stream fifo
  // ==========================================================================
  spc_buf u_buf (
    .mclk(mclk),
    .ce(ce),
    .we(buf_we),
    .waddr(buf_waddr),
    .wdata(buf_wdata),
    .raddr(q.dr_ptr[BUF_AW-1:0]),
    .rdata(buf_rdata)
  );

  spc_fifo #(
    .W($bits(spc_wr_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_word)
  );

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign spi_miso = q.miso;
  assign spi_miso_oe_n = q.oe_n;
  assign rd_req = q.rd_req;
  assign rd_addr = q.rd_addr;
  assign cfg_restore = q.cfg_restore;
  assign soft_restart = q.soft_restart;
  assign write_enabled = q.wen;
endmodule
